/* File: verilog/dac_pkg.sv */
// Purpose: Constants and carriers of the diagnostic and address-mode command block.
// Assumes: Byte-wide command codes written in the low bits of the command register.
// Notes:   Register indices are word addresses on the plain register port.
package dac_pkg;
	localparam logic [7:0] CMD_DIAG      = 8'h0a;
	localparam logic [7:0] CMD_SRC_ON    = 8'h0d;
	localparam logic [7:0] CMD_SRC_OFF   = 8'h0e;
	localparam logic [7:0] CMD_DFLT_ADDR = 8'h0f;
	localparam logic [7:0] CMD_ALLM_ON   = 8'h10;
	localparam logic [7:0] CMD_ALLM_OFF  = 8'h11;
	localparam logic [7:0] CMD_NET_LPBK  = 8'h12;
	localparam logic [7:0] CMD_RESET     = 8'h3f;
	localparam logic [7:0] ST_OK         = 8'h00;
	localparam logic [7:0] ST_RETRY      = 8'h01;
	localparam logic [7:0] ST_ROM_ERR    = 8'h01;
	localparam logic [7:0] ST_RAM_ERR    = 8'h02;
	localparam logic [7:0] ST_ADDR_ERR   = 8'h03;
	localparam logic [7:0] ST_INAPPROP   = 8'h03;
	localparam logic [7:0] ST_LPBK_ERR   = 8'h04;
	localparam logic [7:0] ST_JABBER     = 8'h04;
	localparam logic [7:0] ST_EXCESS     = 8'h08;
	localparam logic [7:0] ST_BADCRC_OK  = 8'h0c;
	localparam logic [7:0] ST_DATA_ERR   = 8'h0d;
	localparam logic [7:0] ST_GOODCRC_BAD = 8'h0e;
	localparam logic [3:0] OFF_CMD       = 4'h0;
	localparam logic [3:0] OFF_STATUS    = 4'h1;
	localparam logic [3:0] OFF_MODE      = 4'h2;
	localparam logic [3:0] OFF_TBL_IDX   = 4'h3;
	localparam logic [3:0] OFF_TBL_LO    = 4'h4;
	localparam logic [3:0] OFF_TBL_HI    = 4'h5;
	localparam int         STAT_DONE_BIT = 8;
	localparam int         STAT_BUSY_BIT = 9;
	localparam int         MODE_SRC_BIT  = 0;
	localparam int         MODE_ALLM_BIT = 1;
	localparam int         MODE_FACT_BIT = 2;
	localparam int         TBL_VLD_BIT   = 16;
	localparam int         GRP_ENTRIES   = 63;
	localparam int         SRC_FIRST     = 6;
	localparam int         SRC_LAST      = 11;
	localparam int         MCAST_BIT     = 40;
	localparam logic       RST_SRC_INS   = 1'b1;
	localparam logic       RST_ALL_MCAST = 1'b0;
	localparam logic       RST_USE_FACT  = 1'b1;
	typedef enum logic [2:0] {
		CS_IDLE = 3'b000,
		CS_DIAG = 3'b001,
		CS_TX1  = 3'b010,
		CS_RX1  = 3'b011,
		CS_TX2  = 3'b100,
		CS_RX2  = 3'b101
	} dac_cmd_state_e;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} dac_bus_s;
	typedef struct packed {
		logic done;
		logic rom_ok;
		logic ram_ok;
		logic addr_ok;
		logic lpbk_ok;
	} dac_diag_res_s;
	typedef struct packed {
		logic done;
		logic collided;
		logic jabber;
		logic excess;
	} dac_tx_res_s;
	typedef struct packed {
		logic done;
		logic crc_err;
		logic last_match;
	} dac_rx_res_s;
	typedef struct packed {
		logic        valid;
		logic [47:0] dst;
	} dac_rx_chk_s;
	typedef struct packed {
		logic       valid;
		logic       sof;
		logic [7:0] data;
	} dac_tx_byte_s;
endpackage

/* File: verilog/dac_cmd.sv */
// Purpose: Command interpreter for diagnostics, source insertion, address and multicast modes.
// Assumes: Self-test, transmitter and receiver engines share mclk and answer with done pulses.
// Notes:   Commands written while a command is running are ignored.
`timescale 1ns/1ps
module dac_cmd #(
	parameter int GRP_N = dac_pkg::GRP_ENTRIES
) (
	input  wire logic                   mclk,         // 20 MHz clock
	input  wire logic                   resetn,       // Asynchronous reset, active low
	input  wire dac_pkg::dac_bus_s      bus,          // Register port request
	output logic [31:0]                 rdata,        // Read data, cycle after read strobe
	input  wire logic                   online,       // Device is online
	input  wire logic [47:0]            factory_addr, // Factory physical address
	input  wire dac_pkg::dac_diag_res_s diag_res,     // Self-test results
	output logic                        diag_start,   // Start self-test pulse
	output logic                        go_offline,   // Take device offline pulse
	output logic                        mem_clear,    // Clear tx and rx memory pulse
	output logic                        tx_restart,   // Restart transmit channel pulse
	output logic                        lb_tx_req,    // Send loopback frame pulse
	output logic                        lb_bad_crc,   // Frame carries a wrong CRC
	input  wire dac_pkg::dac_tx_res_s   lb_tx_res,    // Loopback transmit result
	input  wire dac_pkg::dac_rx_res_s   lb_rx_res,    // Loopback receive result
	input  wire dac_pkg::dac_rx_chk_s   rx_chk,       // Destination to filter
	output logic                        acc_vld,      // Filter verdict pulse
	output logic                        acc,          // Frame accepted
	input  wire dac_pkg::dac_tx_byte_s  tx_in,        // Outgoing frame bytes
	output dac_pkg::dac_tx_byte_s       tx_out,       // Bytes after source insertion
	output logic                        src_insert,   // Source insertion mode
	output logic                        all_mcast,    // Receive all multicast mode
	output logic                        use_factory   // Factory address in use
);
	// ======================================================================
	// Command decode
	dac_pkg::dac_cmd_state_e state_q;
	logic [7:0]  status_q;
	logic        done_q;
	logic        retry_q;
	logic        cmd_wr;
	logic        idle_cmd;
	logic [7:0]  code;
	logic        init_evt;
	assign cmd_wr   = bus.wr && (bus.addr == dac_pkg::OFF_CMD);
	assign code     = bus.wdata[7:0];
	assign idle_cmd = cmd_wr && (state_q == dac_pkg::CS_IDLE);
	assign init_evt = (idle_cmd && code == dac_pkg::CMD_RESET)
		|| (state_q == dac_pkg::CS_DIAG && diag_res.done);

	// ======================================================================
	// Command sequencer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q    <= dac_pkg::CS_IDLE;
			status_q   <= dac_pkg::ST_OK;
			done_q     <= 1'b0;
			retry_q    <= 1'b0;
			diag_start <= 1'b0;
			go_offline <= 1'b0;
			mem_clear  <= 1'b0;
			lb_tx_req  <= 1'b0;
			lb_bad_crc <= 1'b0;
		end else begin
			diag_start <= 1'b0;
			go_offline <= 1'b0;
			mem_clear  <= 1'b0;
			lb_tx_req  <= 1'b0;
			unique case (state_q)
				dac_pkg::CS_IDLE: begin
					if (idle_cmd) begin
						unique case (code)
							dac_pkg::CMD_DIAG: begin
								state_q    <= dac_pkg::CS_DIAG;
								done_q     <= 1'b0;
								diag_start <= 1'b1;
								go_offline <= 1'b1;
								mem_clear  <= 1'b1;
							end
							dac_pkg::CMD_NET_LPBK: begin
								if (!online) begin
									status_q <= dac_pkg::ST_INAPPROP;
									done_q   <= 1'b1;
								end else begin
									state_q    <= dac_pkg::CS_TX1;
									done_q     <= 1'b0;
									retry_q    <= 1'b0;
									lb_tx_req  <= 1'b1;
									lb_bad_crc <= 1'b1;
								end
							end
							dac_pkg::CMD_SRC_ON, dac_pkg::CMD_SRC_OFF, dac_pkg::CMD_DFLT_ADDR,
							dac_pkg::CMD_ALLM_ON, dac_pkg::CMD_ALLM_OFF, dac_pkg::CMD_RESET: begin
								status_q <= dac_pkg::ST_OK;
								done_q   <= 1'b1;
							end
							// Reserved and foreign codes leave everything untouched.
							default: done_q <= done_q;
						endcase
					end
				end
				dac_pkg::CS_DIAG: begin
					if (diag_res.done) begin
						state_q <= dac_pkg::CS_IDLE;
						done_q  <= 1'b1;
						if (!diag_res.rom_ok) status_q <= dac_pkg::ST_ROM_ERR;
						else if (!diag_res.ram_ok) status_q <= dac_pkg::ST_RAM_ERR;
						else if (!diag_res.addr_ok) status_q <= dac_pkg::ST_ADDR_ERR;
						else if (!diag_res.lpbk_ok) status_q <= dac_pkg::ST_LPBK_ERR;
						else status_q <= dac_pkg::ST_OK;
					end
				end
				dac_pkg::CS_TX1, dac_pkg::CS_TX2: begin
					if (lb_tx_res.done) begin
						if (lb_tx_res.jabber) begin
							status_q <= dac_pkg::ST_JABBER;
							done_q   <= 1'b1;
							state_q  <= dac_pkg::CS_IDLE;
						end else if (lb_tx_res.excess) begin
							status_q <= dac_pkg::ST_EXCESS;
							done_q   <= 1'b1;
							state_q  <= dac_pkg::CS_IDLE;
						end else begin
							retry_q <= retry_q | lb_tx_res.collided;
							state_q <= (state_q == dac_pkg::CS_TX1) ? dac_pkg::CS_RX1
								: dac_pkg::CS_RX2;
						end
					end
				end
				dac_pkg::CS_RX1: begin
					if (lb_rx_res.done) begin
						if (!lb_rx_res.crc_err) begin
							status_q <= dac_pkg::ST_BADCRC_OK;
							done_q   <= 1'b1;
							state_q  <= dac_pkg::CS_IDLE;
						end else begin
							state_q    <= dac_pkg::CS_TX2;
							lb_tx_req  <= 1'b1;
							lb_bad_crc <= 1'b0;
						end
					end
				end
				dac_pkg::CS_RX2: begin
					if (lb_rx_res.done) begin
						done_q  <= 1'b1;
						state_q <= dac_pkg::CS_IDLE;
						if (lb_rx_res.crc_err) status_q <= dac_pkg::ST_GOODCRC_BAD;
						else if (!lb_rx_res.last_match) status_q <= dac_pkg::ST_DATA_ERR;
						else status_q <= retry_q ? dac_pkg::ST_RETRY : dac_pkg::ST_OK;
					end
				end
				default: state_q <= dac_pkg::CS_IDLE;
			endcase
		end
	end

	// ======================================================================
	// Mode flags
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			src_insert  <= dac_pkg::RST_SRC_INS;
			all_mcast   <= dac_pkg::RST_ALL_MCAST;
			use_factory <= dac_pkg::RST_USE_FACT;
			tx_restart  <= 1'b0;
		end else begin
			tx_restart <= idle_cmd && (code == dac_pkg::CMD_SRC_ON
				|| code == dac_pkg::CMD_SRC_OFF);
			if (init_evt) begin
				src_insert  <= dac_pkg::RST_SRC_INS;
				all_mcast   <= dac_pkg::RST_ALL_MCAST;
				use_factory <= dac_pkg::RST_USE_FACT;
			end else if (idle_cmd) begin
				if (code == dac_pkg::CMD_SRC_ON) src_insert <= 1'b1;
				if (code == dac_pkg::CMD_SRC_OFF) src_insert <= 1'b0;
				if (code == dac_pkg::CMD_DFLT_ADDR) use_factory <= 1'b1;
				if (code == dac_pkg::CMD_ALLM_ON) all_mcast <= 1'b1;
				if (code == dac_pkg::CMD_ALLM_OFF) all_mcast <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Source address insertion; the count resets on a channel restart, which drops only the byte
	// of that cycle; the rest of a half-sent frame passes on, counted again from zero.
	logic [3:0] tx_cnt_q;
	logic [3:0] tx_idx;
	logic [3:0] src_off;
	assign tx_idx  = tx_in.sof ? 4'h0 : tx_cnt_q;
	assign src_off = tx_idx - 4'(dac_pkg::SRC_FIRST);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_cnt_q <= 4'h0;
			tx_out   <= '0;
		end else begin
			tx_out.valid <= tx_in.valid && !tx_restart;
			tx_out.sof   <= tx_in.sof;
			tx_out.data  <= tx_in.data;
			if (tx_restart) begin
				tx_cnt_q <= 4'h0;
			end else if (tx_in.valid) begin
				if (tx_idx != 4'(dac_pkg::SRC_LAST + 1)) tx_cnt_q <= tx_idx + 4'h1;
				else tx_cnt_q <= tx_idx;
				if (src_insert && tx_idx >= 4'(dac_pkg::SRC_FIRST)
					&& tx_idx <= 4'(dac_pkg::SRC_LAST)) begin
					tx_out.data <= factory_addr[6'(47 - 8 * src_off) -: 8];
				end
			end
		end
	end

	// ======================================================================
	// Destination filter and group table
	logic [47:0] grp_addr [GRP_N];
	logic [5:0]  grp_hash [GRP_N];
	logic [GRP_N-1:0] grp_vld_q;
	logic [5:0]  tbl_idx_q;
	logic [31:0] tbl_lo_q;
	logic [47:0] tbl_new;
	logic        scan_q;
	logic [5:0]  scan_idx_q;
	logic [47:0] dst_q;
	logic [5:0]  dst_hash_q;
	logic        hit;

	function automatic logic [5:0] hash6(input logic [47:0] a);
		hash6 = 6'(a[47:40] ^ a[39:32] ^ a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0]);
	endfunction

	assign tbl_new = {bus.wdata[15:0], tbl_lo_q};
	assign hit     = grp_vld_q[scan_idx_q] && grp_hash[scan_idx_q] == dst_hash_q
		&& grp_addr[scan_idx_q] == dst_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tbl_idx_q <= 6'h00;
			tbl_lo_q  <= 32'h0000_0000;
			grp_vld_q <= '0;
		end else if (bus.wr) begin
			if (bus.addr == dac_pkg::OFF_TBL_IDX) tbl_idx_q <= bus.wdata[5:0];
			if (bus.addr == dac_pkg::OFF_TBL_LO) tbl_lo_q <= bus.wdata;
			if (bus.addr == dac_pkg::OFF_TBL_HI && tbl_idx_q < 6'(GRP_N)) begin
				grp_vld_q[tbl_idx_q] <= bus.wdata[dac_pkg::TBL_VLD_BIT];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (bus.wr && bus.addr == dac_pkg::OFF_TBL_HI && tbl_idx_q < 6'(GRP_N)) begin
			grp_addr[tbl_idx_q] <= tbl_new;
			grp_hash[tbl_idx_q] <= hash6(tbl_new);
		end
	end

	// Loopback frames arrive here too, so the all-multicast bypass covers them.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scan_q     <= 1'b0;
			scan_idx_q <= 6'h00;
			dst_q      <= 48'h0;
			dst_hash_q <= 6'h00;
			acc_vld    <= 1'b0;
			acc        <= 1'b0;
		end else begin
			acc_vld <= 1'b0;
			if (scan_q) begin
				if (hit || scan_idx_q == 6'(GRP_N - 1)) begin
					scan_q  <= 1'b0;
					acc_vld <= 1'b1;
					acc     <= hit;
				end else begin
					scan_idx_q <= scan_idx_q + 6'h01;
				end
			end else if (rx_chk.valid) begin
				if (&rx_chk.dst) begin
					acc_vld <= 1'b1;
					acc     <= 1'b1;
				end else if (rx_chk.dst[dac_pkg::MCAST_BIT]) begin
					if (all_mcast) begin
						acc_vld <= 1'b1;
						acc     <= 1'b1;
					end else begin
						scan_q     <= 1'b1;
						scan_idx_q <= 6'h00;
						dst_q      <= rx_chk.dst;
						dst_hash_q <= hash6(rx_chk.dst);
					end
				end else begin
					acc_vld <= 1'b1;
					acc     <= !use_factory || rx_chk.dst == factory_addr;
				end
			end
		end
	end

	// ======================================================================
	// Read port
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			rdata <= 32'h0000_0000;
			unique case (bus.addr)
				dac_pkg::OFF_STATUS: begin
					rdata[7:0] <= status_q;
					rdata[dac_pkg::STAT_DONE_BIT] <= done_q;
					rdata[dac_pkg::STAT_BUSY_BIT] <= state_q != dac_pkg::CS_IDLE;
				end
				dac_pkg::OFF_MODE: begin
					rdata[dac_pkg::MODE_SRC_BIT]  <= src_insert;
					rdata[dac_pkg::MODE_ALLM_BIT] <= all_mcast;
					rdata[dac_pkg::MODE_FACT_BIT] <= use_factory;
				end
				dac_pkg::OFF_TBL_IDX: rdata[5:0] <= tbl_idx_q;
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ======================================================================
	// Checks
	sequence s_lb_go;
		idle_cmd && code == dac_pkg::CMD_NET_LPBK && online;
	endsequence
	sequence s_diag_go;
		idle_cmd && code == dac_pkg::CMD_DIAG;
	endsequence

	a_diag_offline_clear: assert property (@(posedge mclk) disable iff (!resetn)
		s_diag_go |=> go_offline && mem_clear && diag_start && !done_q)
		else $error("diagnostics did not go offline and clear memory");
	a_diag_pass_code: assert property (@(posedge mclk) disable iff (!resetn)
		state_q == dac_pkg::CS_DIAG && diag_res == 5'b11111 |=> status_q == 8'h00 && done_q)
		else $error("passing diagnostics did not post 00");
	a_diag_rom_code: assert property (@(posedge mclk) disable iff (!resetn)
		state_q == dac_pkg::CS_DIAG && diag_res.done && !diag_res.rom_ok |=> status_q == 8'h01)
		else $error("checksum fault did not post 01");
	a_diag_init_modes: assert property (@(posedge mclk) disable iff (!resetn)
		state_q == dac_pkg::CS_DIAG && diag_res.done |=> src_insert && use_factory && !all_mcast)
		else $error("diagnostics did not restore default modes");
	a_src_restart: assert property (@(posedge mclk) disable iff (!resetn)
		idle_cmd && code == dac_pkg::CMD_SRC_OFF |=> tx_restart && !src_insert)
		else $error("clearing insertion did not restart transmit channel");
	a_src_overwrite: assert property (@(posedge mclk) disable iff (!resetn)
		tx_in.valid && !tx_in.sof && tx_cnt_q == 4'h6 && src_insert && !tx_restart
		|=> tx_out.data == $past(factory_addr[47:40]))
		else $error("first source byte not replaced");
	a_lb_offline: assert property (@(posedge mclk) disable iff (!resetn)
		idle_cmd && code == dac_pkg::CMD_NET_LPBK && !online |=> status_q == 8'h03 && done_q)
		else $error("offline loopback did not post 03");
	a_lb_first_bad: assert property (@(posedge mclk) disable iff (!resetn)
		s_lb_go |=> lb_tx_req && lb_bad_crc ##1 !lb_tx_req)
		else $error("loopback did not start with a bad CRC frame");
	a_lb_jabber: assert property (@(posedge mclk) disable iff (!resetn)
		state_q == dac_pkg::CS_TX1 && lb_tx_res.done && lb_tx_res.jabber
		|=> status_q == 8'h04 && state_q == dac_pkg::CS_IDLE)
		else $error("jabber did not post 04");
	a_rx_badcrc: assert property (@(posedge mclk) disable iff (!resetn)
		state_q == dac_pkg::CS_RX1 && lb_rx_res.done && !lb_rx_res.crc_err |=> status_q == 8'h0c)
		else $error("accepted bad CRC did not post 0C");
	a_mcast_all: assert property (@(posedge mclk) disable iff (!resetn)
		!scan_q && rx_chk.valid && rx_chk.dst[40] && !(&rx_chk.dst) && all_mcast |=> acc_vld && acc)
		else $error("multicast not accepted in receive-all mode");
	a_grp_scan_bound: assert property (@(posedge mclk) disable iff (!resetn)
		!scan_q && rx_chk.valid && rx_chk.dst[40] && !(&rx_chk.dst) && !all_mcast
		|-> ##[1:64] acc_vld)
		else $error("group table scan exceeded 63 entries");
endmodule

/* File: verification/dac_far.sv */
// Purpose: Far-side engines: self-test, loopback transmitter and receiver.
// Assumes: The bench sets the fault selects before each command.
// Notes:   Result fields are inverted outside done, so stale values never pass.
`timescale 1ns/1ps
module dac_far (
	input  wire logic              mclk,   // Clock
	input  wire logic              resetn, // Reset, active low
	input  wire logic              dstart, // Self-test start
	input  wire logic              txreq,  // Frame send request
	input  wire logic              badcrc, // Frame carries a wrong CRC
	input  wire logic [3:0]        dok,    // Self-test pass flags
	input  wire logic [2:0]        txf,    // Collided, jabber, excess
	input  wire logic [1:0]        rxm,    // Receive fault mode
	input  wire logic              slow,   // Long answer times
	output dac_pkg::dac_diag_res_s dres,   // Self-test result
	output dac_pkg::dac_tx_res_s   tres,   // Transmit result
	output dac_pkg::dac_rx_res_s   rres    // Receive result
);
	int   dc_q, tc_q, rc_q;
	logic bad_q;
	wire  dd = dc_q == 1;
	wire  td = tc_q == 1;
	wire  rd = rc_q == 1;
	// ==========
	// Engines
	// The real self-test takes seconds; it is shortened so the run stays brief.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dc_q <= 0;
			tc_q <= 0;
			rc_q <= 0;
			bad_q <= 1'b0;
		end else begin
			dc_q <= dstart ? (slow ? 40 : 3) : (dc_q > 0 ? dc_q - 1 : 0);
			tc_q <= txreq ? (slow ? 9 : 2) : (tc_q > 0 ? tc_q - 1 : 0);
			rc_q <= (td && txf[1:0] == 2'b00) ? 2 : (rc_q > 0 ? rc_q - 1 : 0);
			if (txreq)
				bad_q <= badcrc;
		end
	end
	wire ce = bad_q ? (rxm != 2'd1) : (rxm == 2'd2);
	wire lm = rxm != 2'd3;
	assign dres = {dd, dd ? dok : ~dok};
	assign tres = {td, td ? txf : ~txf};
	assign rres = {rd, rd ? {ce, lm} : ~{ce, lm}};
endmodule

/* File: verification/dac_cmd_test.sv */
// Purpose: Self-checking bench of the command interpreter.
// Assumes: Far-side engines come from dac_far; expectations from a bench model.
// Notes:   The host polls status instead of waiting a fixed time.
`timescale 1ns/1ps
module dac_cmd_test;
	logic                   mclk = 1'b0;
	logic                   resetn = 1'b0;
	logic                   online = 1'b0;
	logic                   slow = 1'b0;
	logic [3:0]             dok = 4'hf;
	logic [2:0]             txf = 3'h0;
	logic [1:0]             rxm = 2'h0;
	logic [47:0]            fa = 48'h0;
	dac_pkg::dac_bus_s      bus = '0;
	dac_pkg::dac_rx_chk_s   rx_chk = '0;
	dac_pkg::dac_tx_byte_s  tx_in = '0;
	dac_pkg::dac_tx_byte_s  tx_out;
	dac_pkg::dac_diag_res_s dres;
	dac_pkg::dac_tx_res_s   tres;
	dac_pkg::dac_rx_res_s   rres;
	logic [31:0]            rdata, rv;
	logic                   ds, goff, mclr, txr, lreq, lbad, accv, acc, src, allm, fact;
	int                     failures = 0, compares = 0, cyc = 0, pat = 0, nreq = 0, n;
	logic                   m_src = 1'b1, m_allm = 1'b0;
	logic [47:0]            grp[$], gd[3], fl[6];
	logic [7:0]             q[$], c;
	logic [7:0]  cl[9] = '{8'h0e, 8'h10, 8'h0b, 8'h0c, 8'h3f, 8'h10, 8'h0d, 8'h11, 8'h0f};
	logic [5:0]  ti[3] = '{6'd0, 6'd62, 6'd63};
	logic [3:0]  dk[5] = '{4'hf, 4'h7, 4'hb, 4'hd, 4'he};
	logic [13:0] lb[8] = '{14'h0003, 14'h2000, 14'h3001, 14'h2804, 14'h2408, 14'h210c,
		14'h220e, 14'h230d};
	dac_cmd uut (.mclk, .resetn, .bus, .rdata, .online, .factory_addr(fa), .diag_res(dres),
		.diag_start(ds), .go_offline(goff), .mem_clear(mclr), .tx_restart(txr),
		.lb_tx_req(lreq), .lb_bad_crc(lbad), .lb_tx_res(tres), .lb_rx_res(rres), .rx_chk,
		.acc_vld(accv), .acc, .tx_in, .tx_out, .src_insert(src), .all_mcast(allm),
		.use_factory(fact));
	dac_far far (.mclk, .resetn, .dstart(ds), .txreq(lreq), .badcrc(lbad), .dok, .txf,
		.rxm, .slow, .dres, .tres, .rres);
	// ==========
	// Clock, frame log and hang guard
	initial begin
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (lreq) begin
			nreq++;
			pat = pat * 2 + lbad;
		end
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	// ==========
	// Host tasks and model
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge mclk);
		bus <= '0;
		@(negedge mclk);
		d = rdata;
	endtask
	task automatic cmd(input logic [7:0] k, input logic [7:0] st);
		wr(dac_pkg::OFF_CMD, {24'h0, k});
		@(negedge mclk);
		chk("tx_restart", 48'(k == 8'h0d || k == 8'h0e), 48'(txr));
		chk("diag pulses", {45'h0, {3{k == 8'h0a}}}, {45'h0, ds, goff, mclr});
		rv = 32'h0;
		for (int i = 0; i < 100 && rv[8] !== 1'b1; i++) rd(dac_pkg::OFF_STATUS, rv);
		chk("status", {38'h0, 2'b01, st}, 48'(rv[9:0]));
	endtask
	task automatic mode();
		rd(dac_pkg::OFF_MODE, rv);
		chk("mode", {45'h0, 1'b1, m_allm, m_src}, 48'(rv[2:0]));
		chk("mode pins", {45'h0, 1'b1, m_allm, m_src}, {45'h0, fact, allm, src});
	endtask
	function automatic logic want(input logic [47:0] d);
		logic h = m_allm;
		foreach (grp[i]) h |= grp[i] == d;
		return d == '1 || (d[40] ? h : d == fa);
	endfunction
	task automatic filt(input logic [47:0] d);
		@(posedge mclk);
		rx_chk <= '{1'b1, d};
		@(posedge mclk);
		rx_chk <= '0;
		for (int i = 0; i < 80 && accv !== 1'b1; i++) @(negedge mclk);
		chk("verdict", {46'h0, 1'b1, want(d)}, {46'h0, accv, acc});
	endtask
	task automatic frame();
		logic [7:0] e;
		for (int i = 0; i < 15; i++) begin
			@(posedge mclk);
			q.push_back(8'($urandom()));
			tx_in <= '{i < 14, i == 0, q[i]};
			@(negedge mclk);
			e = (m_src && i > 6 && i < 13) ? fa[8*(12-i)+:8] : q[(i > 0) ? i - 1 : 0];
			if (i > 0) chk("tx_out", {38'h0, 1'b1, i == 1, e}, 48'(tx_out));
		end
		q.delete();
	endtask
	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========
	// Tests
	initial begin
		void'($urandom(32'h18902caa));
		fa = 48'({$urandom(), $urandom()}) & ~48'h0100_0000_0000;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		mode();
		$display("test reset done");
		foreach (ti[i]) begin
			gd[i] = 48'({$urandom(), $urandom()}) | 48'h0100_0000_0000;
			wr(dac_pkg::OFF_TBL_IDX, {26'h0, ti[i]});
			wr(dac_pkg::OFF_TBL_LO, gd[i][31:0]);
			wr(dac_pkg::OFF_TBL_HI, {15'h0, 1'b1, gd[i][47:32]});
			if (ti[i] < 6'd63) grp.push_back(gd[i]);
		end
		foreach (cl[i]) begin
			cmd(cl[i], 8'h00);
			m_src = (cl[i] == 8'h0e) ? 1'b0 : (cl[i] == 8'h0d || cl[i] == 8'h3f) ? 1'b1 : m_src;
			m_allm = (cl[i] == 8'h10) ? 1'b1 : (cl[i] == 8'h11 || cl[i] == 8'h3f) ? 1'b0 : m_allm;
			mode();
			frame();
			fl = '{gd[1], gd[2], '1, fa, 48'($urandom()) | 48'h0100_0000_0000, 48'($urandom())};
			foreach (fl[j]) filt(fl[j]);
		end
		$display("test modes done");
		foreach (dk[i]) begin
			cmd(8'h0e, 8'h00);
			cmd(8'h10, 8'h00);
			@(posedge mclk);
			dok <= dk[i];
			slow <= i == 1;
			cmd(8'h0a, 8'(i));
			m_src = 1'b1;
			m_allm = 1'b0;
			mode();
			if (i > 0) cmd(8'h3f, 8'h00);
		end
		$display("test diagnostics done");
		foreach (lb[i]) begin
			@(posedge mclk);
			{online, txf, rxm} <= lb[i][13:8];
			c = lb[i][7:0];
			pat = 0;
			nreq = 0;
			cmd(8'h12, c);
			n = c == 8'h03 ? 0 : (c == 8'h04 || c == 8'h08 || c == 8'h0c) ? 1 : 2;
			chk("frames sent", 48'(n), 48'(nreq));
			chk("crc pattern", 48'(n), 48'(pat));
		end
		$display("test loopback done");
		summarize();
	end
endmodule
